// File: dpll_host.sv
// host end: apb controlled sequencer for the clock multiplier setup
`timescale 1ns/1ns
`include "dpll_defines.svh"
// Overview of operation
// - bypass register 0x00 pll, 0x01 direct clock
// - first companion 0xFF bypass, 0x00 pll
// - second companion 0x00 pll, bypass value
// - bypass: two companion writes, then stop
// - fixed setup writes in given order
// - charge pump current 0x04 to 0x10
// - adc clock divide code n minus one
// - feedback divider from clock ratio formula
// - predivide code n minus one
// - phase detector between 25 and 770 MHz
// - vco band limits detector to 225 MHz
// - keep upper predivider and divide bits
// - third select divides vco by three
// - half and third never set together
// - pulse vco reset, wait, check lock
module dpll_host #(
  parameter int unsigned PAUSE_CYCLES = `DPLL_PAUSE_MS * 1000000 / `DPLL_CLK_NS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link
  dpll_if.host link
);
  // ============================================================
  // configuration checks
  function automatic logic dpll_cfg_ok(input logic [31:0] cfg, input logic [31:0] rf);
    logic [13:0] m;
    logic [13:0] r;
    logic [5:0] cp;
    logic [5:0] n;
    m = {12'h000, cfg[17:16]} + 14'h0001;
    r = {2'b00, rf[11:0]};
    cp = cfg[5:0];
    n = cfg[13:8];
    dpll_cfg_ok = 1'b1;
    if (cp < `DPLL_CP_MIN || cp > `DPLL_CP_MAX) begin
      dpll_cfg_ok = 1'b0;
    end
    if (n < `DPLL_N_MIN || n > `DPLL_N_MAX) begin
      dpll_cfg_ok = 1'b0;
    end
    if (cfg[20] & cfg[21]) begin
      dpll_cfg_ok = 1'b0;
    end
    if (r < `DPLL_PFD_MIN_MHZ * m || r > `DPLL_PFD_MAX_MHZ * m) begin
      dpll_cfg_ok = 1'b0;
    end
    if (rf[16] && r > `DPLL_PFD_BAND_MHZ * m) begin
      dpll_cfg_ok = 1'b0;
    end
  endfunction

  // ============================================================
  // step table
  function automatic dpll_pkg::dpll_addr_t dpll_step_addr(input logic [4:0] s);
    case (s)
      5'h00: dpll_step_addr = `DPLL_A_BYPASS;
      5'h01: dpll_step_addr = `DPLL_A_COMP_A;
      5'h02: dpll_step_addr = `DPLL_A_COMP_B;
      5'h03: dpll_step_addr = `DPLL_A_SETUP_A;
      5'h04: dpll_step_addr = `DPLL_A_SETUP_D;
      5'h05: dpll_step_addr = `DPLL_A_CP;
      5'h06: dpll_step_addr = `DPLL_A_SETUP_B;
      5'h07: dpll_step_addr = `DPLL_A_SETUP_B;
      5'h08: dpll_step_addr = `DPLL_A_SETUP_C;
      5'h09: dpll_step_addr = `DPLL_A_SETUP_E;
      5'h0A: dpll_step_addr = `DPLL_A_FBDIV;
      5'h0B: dpll_step_addr = `DPLL_A_PRED;
      5'h0C: dpll_step_addr = `DPLL_A_VCO_DIV;
      5'h0D: dpll_step_addr = `DPLL_A_VCO_RST;
      5'h0E: dpll_step_addr = `DPLL_A_VCO_RST;
      default: dpll_step_addr = `DPLL_A_LOCK;
    endcase
  endfunction

  function automatic dpll_pkg::dpll_byte_t dpll_step_data(input logic [4:0] s,
                                                          input logic byp,
                                                          input logic [31:0] cfg);
    case (s)
      5'h00: dpll_step_data = byp ? `DPLL_V_BYPASS : `DPLL_V_USE_PLL;
      5'h01: dpll_step_data = byp ? `DPLL_V_COMP_BYP_A : `DPLL_V_COMP_PLL;
      5'h02: dpll_step_data = byp ? `DPLL_V_COMP_BYP_B : `DPLL_V_COMP_PLL;
      5'h03: dpll_step_data = `DPLL_V_SETUP_A;
      5'h04: dpll_step_data = `DPLL_V_SETUP_D;
      5'h05: dpll_step_data = {2'b00, cfg[5:0]};
      5'h06: dpll_step_data = `DPLL_V_SETUP_B1;
      5'h07: dpll_step_data = `DPLL_V_SETUP_B2;
      5'h08: dpll_step_data = `DPLL_V_SETUP_C;
      5'h09: dpll_step_data = `DPLL_V_SETUP_E;
      5'h0A: dpll_step_data = {cfg[19:18], cfg[13:8]};
      5'h0B: dpll_step_data = {`DPLL_PRED_UPPER, cfg[17:16]};
      5'h0C: dpll_step_data = {`DPLL_VDIV_UPPER, cfg[21:20]};
      5'h0D: dpll_step_data = `DPLL_V_VCO_RST_ON;
      5'h0E: dpll_step_data = `DPLL_V_VCO_RST_OFF;
      default: dpll_step_data = 8'h00;
    endcase
  endfunction

  // ============================================================
  // state
  dpll_pkg::dpll_state_e state_ff;
  dpll_pkg::dpll_state_e nxt_state;
  logic [4:0] step_ff;
  logic [4:0] nxt_step;
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic [31:0] cfg_ff;
  logic [31:0] ref_ff;
  logic bypass_ff;
  logic busy_ff;
  logic done_ff;
  logic locked_ff;
  logic cfg_err_ff;
  logic lock_fail_ff;
  dpll_pkg::dpll_addr_t addr_ff;
  dpll_pkg::dpll_byte_t wdata_ff;
  logic we_ff;
  logic [31:0] prdata_ff;

  // ============================================================
  // apb decode
  wire apb_wr = psel & penable & pwrite;
  wire sel_ctrl = paddr == `DPLL_APB_CTRL;
  wire sel_cfg = paddr == `DPLL_APB_CFG;
  wire sel_ref = paddr == `DPLL_APB_REF;
  wire sel_stat = paddr == `DPLL_APB_STAT;
  wire mapped = sel_ctrl | sel_cfg | sel_ref | sel_stat;
  wire idle = state_ff == dpll_pkg::DPLL_IDLE;
  // settings are frozen while a sequence runs
  wire wr_ctrl = apb_wr & sel_ctrl & idle;
  wire wr_cfg = apb_wr & sel_cfg & idle;
  wire wr_ref = apb_wr & sel_ref & idle;
  wire start = wr_ctrl & pwdata[`DPLL_CTRL_START];
  wire start_byp = pwdata[`DPLL_CTRL_BYPASS];
  wire cfg_good = dpll_cfg_ok(cfg_ff, ref_ff);
  wire launch = start & (start_byp | cfg_good);
  wire reject = start & ~start_byp & ~cfg_good;
  wire [31:0] stat_word = {27'h0000000, lock_fail_ff, cfg_err_ff, locked_ff, done_ff, busy_ff};
  wire [31:0] ctrl_word = {30'h0000000, bypass_ff, 1'b0};

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  wire [31:0] rd_mux = sel_ctrl ? ctrl_word :
                       sel_cfg ? cfg_ff :
                       sel_ref ? ref_ff :
                       sel_stat ? stat_word : 32'h00000000;
  assign prdata = prdata_ff;

  // ============================================================
  // sequencer
  wire acked = (state_ff == dpll_pkg::DPLL_REQ) & link.ack;
  wire byp_end = bypass_ff & (step_ff == `DPLL_STEP_BYP_LAST);
  wire read_end = step_ff == `DPLL_STEP_READ;
  wire to_pause = ~bypass_ff & ((step_ff == `DPLL_STEP_PAUSE1) |
                                (step_ff == `DPLL_STEP_PAUSE2));
  wire pause_end = (state_ff == dpll_pkg::DPLL_PAUSE) & (cnt_ff == 32'h00000000);
  wire finish = acked & (byp_end | read_end);
  wire advance = (acked & ~finish & ~to_pause) | pause_end;

  always_comb begin
    nxt_state = state_ff;
    nxt_step = step_ff;
    nxt_cnt = cnt_ff;
    unique case (state_ff)
      dpll_pkg::DPLL_IDLE: begin
        if (launch) begin
          nxt_state = dpll_pkg::DPLL_REQ;
          nxt_step = 5'h00;
        end
      end
      dpll_pkg::DPLL_REQ: begin
        if (finish) begin
          nxt_state = dpll_pkg::DPLL_IDLE;
        end else if (acked & to_pause) begin
          nxt_state = dpll_pkg::DPLL_PAUSE;
          nxt_cnt = PAUSE_CYCLES - 32'h00000001;
        end else if (acked) begin
          nxt_step = step_ff + 5'h01;
        end
      end
      dpll_pkg::DPLL_PAUSE: begin
        if (pause_end) begin
          nxt_state = dpll_pkg::DPLL_REQ;
          nxt_step = step_ff + 5'h01;
        end else begin
          nxt_cnt = cnt_ff - 32'h00000001;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= dpll_pkg::DPLL_IDLE;
      step_ff <= 5'h00;
      cnt_ff <= 32'h00000000;
    end else begin
      state_ff <= nxt_state;
      step_ff <= nxt_step;
      cnt_ff <= nxt_cnt;
    end
  end

  // ============================================================
  // link request fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_ff <= 12'h000;
      wdata_ff <= 8'h00;
      we_ff <= 1'b0;
    end else if (launch | advance) begin
      addr_ff <= dpll_step_addr(nxt_step);
      wdata_ff <= dpll_step_data(nxt_step, launch ? start_byp : bypass_ff, cfg_ff);
      we_ff <= nxt_step != `DPLL_STEP_READ;
    end
  end

  assign link.req = state_ff == dpll_pkg::DPLL_REQ;
  assign link.we = we_ff;
  assign link.addr = addr_ff;
  assign link.wdata = wdata_ff;

  // ============================================================
  // software registers and status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= 32'h00000000;
      ref_ff <= 32'h00000000;
      bypass_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      locked_ff <= 1'b0;
      cfg_err_ff <= 1'b0;
      lock_fail_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      // read word captured in the setup cycle
      if (psel & ~penable) begin
        prdata_ff <= rd_mux;
      end
      if (wr_cfg) begin
        cfg_ff <= {10'h000, pwdata[21:16], 2'b00, pwdata[13:8], 2'b00, pwdata[5:0]};
      end
      if (wr_ref) begin
        ref_ff <= {15'h0000, pwdata[16], 4'h0, pwdata[11:0]};
      end
      if (launch) begin
        bypass_ff <= start_byp;
      end
      busy_ff <= launch | (busy_ff & ~finish);
      done_ff <= finish | (done_ff & ~start);
      cfg_err_ff <= reject | (cfg_err_ff & ~start);
      if (start) begin
        locked_ff <= 1'b0;
        lock_fail_ff <= 1'b0;
      end
      if (acked & read_end) begin
        locked_ff <= link.rdata[`DPLL_F_LOCK];
        lock_fail_ff <= ~link.rdata[`DPLL_F_LOCK];
      end
    end
  end
endmodule

// File: dpll_defines.svh
// constants for the clock multiplier setup sequence
`ifndef DPLL_DEFINES_SVH
`define DPLL_DEFINES_SVH
// ============================================================
// device register addresses
`define DPLL_A_VCO_DIV 12'h094
`define DPLL_A_BYPASS 12'h095
`define DPLL_A_COMP_A 12'h790
`define DPLL_A_COMP_B 12'h791
`define DPLL_A_VCO_RST 12'h792
`define DPLL_A_PRED 12'h793
`define DPLL_A_CP 12'h794
`define DPLL_A_SETUP_A 12'h796
`define DPLL_A_SETUP_B 12'h797
`define DPLL_A_SETUP_C 12'h798
`define DPLL_A_FBDIV 12'h799
`define DPLL_A_SETUP_D 12'h7A0
`define DPLL_A_SETUP_E 12'h7A2
`define DPLL_A_LOCK 12'h7B5
// ============================================================
// device register values
`define DPLL_V_USE_PLL 8'h00
`define DPLL_V_BYPASS 8'h01
`define DPLL_V_COMP_BYP_A 8'hFF
`define DPLL_V_COMP_BYP_B 8'hFF
`define DPLL_V_COMP_PLL 8'h00
`define DPLL_V_SETUP_A 8'hE5
`define DPLL_V_SETUP_D 8'hBC
`define DPLL_V_SETUP_B1 8'h10
`define DPLL_V_SETUP_B2 8'h20
`define DPLL_V_SETUP_C 8'h10
`define DPLL_V_SETUP_E 8'h7F
`define DPLL_V_VCO_RST_ON 8'h02
`define DPLL_V_VCO_RST_OFF 8'h00
`define DPLL_PRED_UPPER 6'h06
`define DPLL_VDIV_UPPER 6'h00
`define DPLL_PRED_RESET 8'h18
`define DPLL_REG_RESET 8'h00
`define DPLL_NUM_REGS 13
`define DPLL_IDX_NONE 4'hF
`define DPLL_IDX_PRED 4'h5
`define DPLL_IDX_VCO_RST 4'h4
// ============================================================
// field positions
`define DPLL_F_BYPASS 0
`define DPLL_F_HALF 0
`define DPLL_F_THIRD 1
`define DPLL_F_CAL 1
`define DPLL_F_LOCK 0
// ============================================================
// limits
`define DPLL_CP_MIN 6'h04
`define DPLL_CP_MAX 6'h10
`define DPLL_N_MIN 6'h02
`define DPLL_N_MAX 6'h32
`define DPLL_PFD_MIN_MHZ 14'h0019
`define DPLL_PFD_MAX_MHZ 14'h0302
`define DPLL_PFD_BAND_MHZ 14'h00E1
// ============================================================
// timing
`define DPLL_CLK_NS 4
`define DPLL_PAUSE_MS 100
// ============================================================
// host apb map
`define DPLL_APB_CTRL 12'h000
`define DPLL_APB_CFG 12'h004
`define DPLL_APB_REF 12'h008
`define DPLL_APB_STAT 12'h00C
`define DPLL_CTRL_START 0
`define DPLL_CTRL_BYPASS 1
`define DPLL_STEP_BYP_LAST 5'h02
`define DPLL_STEP_PAUSE1 5'h09
`define DPLL_STEP_PAUSE2 5'h0E
`define DPLL_STEP_READ 5'h0F
`endif

// File: dpll_pkg.sv
// types shared by both ends of the setup link
package dpll_pkg;
  typedef logic [11:0] dpll_addr_t;
  typedef logic [7:0] dpll_byte_t;
  typedef enum logic [1:0] {
    DPLL_IDLE = 2'b00,
    DPLL_REQ = 2'b01,
    DPLL_PAUSE = 2'b11
  } dpll_state_e;
endpackage

// File: dpll_if.sv
// register access link between host and device
`timescale 1ns/1ns
interface dpll_if;
  logic req;
  logic we;
  dpll_pkg::dpll_addr_t addr;
  dpll_pkg::dpll_byte_t wdata;
  logic ack;
  dpll_pkg::dpll_byte_t rdata;
  modport host (output req, output we, output addr, output wdata, input ack, input rdata);
  modport dev (input req, input we, input addr, input wdata, output ack, output rdata);
endinterface

// File: dpll_dev.sv
// device end: clock multiplier configuration registers
`timescale 1ns/1ns
`include "dpll_defines.svh"
module dpll_dev (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link
  dpll_if.dev link,
  // analog side
  input wire logic pll_locked,
  output logic bypass_en,
  output logic [5:0] charge_pump_current,
  output logic [5:0] feedback_div,
  output logic [2:0] predivide_ratio,
  output logic [2:0] adc_clk_ratio,
  output logic [1:0] vco_ratio,
  output logic div_conflict,
  output logic vco_cal_start
);
  // ============================================================
  // address decode
  function automatic logic [3:0] dpll_reg_index(input dpll_pkg::dpll_addr_t a);
    case (a)
      `DPLL_A_VCO_DIV: dpll_reg_index = 4'h0;
      `DPLL_A_BYPASS: dpll_reg_index = 4'h1;
      `DPLL_A_COMP_A: dpll_reg_index = 4'h2;
      `DPLL_A_COMP_B: dpll_reg_index = 4'h3;
      `DPLL_A_VCO_RST: dpll_reg_index = 4'h4;
      `DPLL_A_PRED: dpll_reg_index = 4'h5;
      `DPLL_A_CP: dpll_reg_index = 4'h6;
      `DPLL_A_SETUP_A: dpll_reg_index = 4'h7;
      `DPLL_A_SETUP_B: dpll_reg_index = 4'h8;
      `DPLL_A_SETUP_C: dpll_reg_index = 4'h9;
      `DPLL_A_FBDIV: dpll_reg_index = 4'hA;
      `DPLL_A_SETUP_D: dpll_reg_index = 4'hB;
      `DPLL_A_SETUP_E: dpll_reg_index = 4'hC;
      default: dpll_reg_index = `DPLL_IDX_NONE;
    endcase
  endfunction

  dpll_pkg::dpll_byte_t regs_ff [`DPLL_NUM_REGS];
  logic ack_ff;
  dpll_pkg::dpll_byte_t rdata_ff;
  logic cal_ff;

  wire [3:0] idx = dpll_reg_index(link.addr);
  wire take = link.req & ~ack_ff;
  wire hit = idx != `DPLL_IDX_NONE;
  wire wr_hit = take & link.we & hit;
  wire lock_sel = link.addr == `DPLL_A_LOCK;
  wire dpll_pkg::dpll_byte_t rd_val = lock_sel ? {7'h00, pll_locked} :
                                      hit ? regs_ff[idx] : 8'h00;
  // falling edge of the calibration bit starts vco calibration
  wire nxt_cal = wr_hit & (idx == `DPLL_IDX_VCO_RST) &
                 regs_ff[`DPLL_IDX_VCO_RST][`DPLL_F_CAL] & ~link.wdata[`DPLL_F_CAL];

  // ============================================================
  // register file and link answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `DPLL_NUM_REGS; i++) begin
        regs_ff[i] <= (i == `DPLL_IDX_PRED) ? `DPLL_PRED_RESET : `DPLL_REG_RESET;
      end
      ack_ff <= 1'b0;
      rdata_ff <= 8'h00;
      cal_ff <= 1'b0;
    end else begin
      if (wr_hit) begin
        regs_ff[idx] <= link.wdata;
      end
      ack_ff <= take;
      if (take) begin
        rdata_ff <= rd_val;
      end
      cal_ff <= nxt_cal;
    end
  end

  assign link.ack = ack_ff;
  assign link.rdata = rdata_ff;

  // ============================================================
  // clock path controls
  wire dpll_pkg::dpll_byte_t vdiv = regs_ff[0];
  wire dpll_pkg::dpll_byte_t fbr = regs_ff[10];
  wire dpll_pkg::dpll_byte_t prr = regs_ff[5];
  assign bypass_en = regs_ff[1][`DPLL_F_BYPASS];
  assign charge_pump_current = regs_ff[6][5:0];
  assign feedback_div = fbr[5:0];
  assign adc_clk_ratio = {1'b0, fbr[7:6]} + 3'h1;
  assign predivide_ratio = {1'b0, prr[1:0]} + 3'h1;
  assign vco_ratio = vdiv[`DPLL_F_THIRD] ? 2'h3 :
                     vdiv[`DPLL_F_HALF] ? 2'h2 : 2'h1;
  assign div_conflict = vdiv[`DPLL_F_THIRD] & vdiv[`DPLL_F_HALF];
  assign vco_cal_start = cal_ff;
endmodule

// File: dpll_link_monitor.sv
// link checker for the clock multiplier setup sequence
`timescale 1ns/1ns
`include "dpll_defines.svh"
module dpll_link_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link
  input wire logic req,
  input wire logic we,
  input wire dpll_pkg::dpll_addr_t addr,
  input wire dpll_pkg::dpll_byte_t wdata,
  input wire logic ack,
  input wire dpll_pkg::dpll_byte_t rdata
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // taken write with its address and byte
  wire take = req && !ack && we;
  wire [20:0] w = {take, addr, wdata};
  // ==========================================================
  // handshake
  property p_ack_pulse;
    ack |=> !ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_answer;
    req && !ack |=> ack && $stable(addr) && $stable(wdata) && $stable(we);
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered or not held");
  // ==========================================================
  // sequence order
  property p_byp;
    w == {1'b1, `DPLL_A_BYPASS, `DPLL_V_BYPASS} |-> ##2 w == {1'b1, `DPLL_A_COMP_A, 8'hFF}
      ##2 w == {1'b1, `DPLL_A_COMP_B, 8'hFF} ##2 !req [*8];
  endproperty
  a_byp: assert property (p_byp) else $error("bypass sequence wrong");
  property p_pll;
    w == {1'b1, `DPLL_A_BYPASS, 8'h00} |-> ##2 w == {1'b1, `DPLL_A_COMP_A, 8'h00}
      ##2 w == {1'b1, `DPLL_A_COMP_B, 8'h00} ##2 w == {1'b1, `DPLL_A_SETUP_A, 8'hE5}
      ##2 w == {1'b1, `DPLL_A_SETUP_D, 8'hBC} ##2 (take && addr == `DPLL_A_CP);
  endproperty
  a_pll: assert property (p_pll) else $error("pll head sequence wrong");
  property p_setup;
    take && addr == `DPLL_A_CP |-> (wdata[5:0] >= 6'h04 && wdata[5:0] <= 6'h10)
      ##2 w == {1'b1, `DPLL_A_SETUP_B, 8'h10} ##2 w == {1'b1, `DPLL_A_SETUP_B, 8'h20}
      ##2 w == {1'b1, `DPLL_A_SETUP_C, 8'h10} ##2 w == {1'b1, `DPLL_A_SETUP_E, 8'h7F}
      ##2 !req [*8];
  endproperty
  a_setup: assert property (p_setup) else $error("setup writes or pause wrong");
  property p_fb_range;
    take && addr == `DPLL_A_FBDIV |-> wdata[5:0] >= 6'h02 && wdata[5:0] <= 6'h32;
  endproperty
  a_fb_range: assert property (p_fb_range) else $error("feedback divider out of range");
  property p_div;
    take && addr == `DPLL_A_FBDIV |-> ##2 (take && addr == `DPLL_A_PRED && wdata[7:2] == 6'h06)
      ##2 (take && addr == `DPLL_A_VCO_DIV && wdata[7:2] == 6'h00 && !(wdata[1] && wdata[0]))
      ##2 w == {1'b1, `DPLL_A_VCO_RST, 8'h02} ##2 w == {1'b1, `DPLL_A_VCO_RST, 8'h00};
  endproperty
  a_div: assert property (p_div) else $error("divider writes wrong");
  property p_lock;
    w == {1'b1, `DPLL_A_VCO_RST, 8'h00} |-> ##2 !req [*8]
      ##[1:40] (req && !we && addr == `DPLL_A_LOCK);
  endproperty
  a_lock: assert property (p_lock) else $error("lock read missing after pause");
  c_byp: cover property (w == {1'b1, `DPLL_A_BYPASS, 8'h01});
  c_cal: cover property (w == {1'b1, `DPLL_A_VCO_RST, 8'h00});
  c_read: cover property (req && ack && !we && rdata[0]);
endmodule

// File: tb.sv
// self-checking bench for the clock multiplier setup link
`timescale 1ns/1ns
`include "dpll_defines.svh"
module tb;
  logic pclk, presetn, psel, penable, pwrite, pll_locked, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic bypass_en, div_conflict, vco_cal_start;
  logic [5:0] charge_pump_current, feedback_div;
  logic [2:0] predivide_ratio, adc_clk_ratio;
  logic [1:0] vco_ratio;
  int failures = 0;
  int cmp_count = 0;
  int cal_cnt = 0;
  logic [31:0] bad_cfg [6] = '{32'h0030_2008, 32'h0000_2003, 32'h0000_2011, 32'h0000_3308,
    32'h0000_2008, 32'h0000_2008};
  logic [31:0] bad_ref [6] = '{32'h12C, 32'h12C, 32'h12C, 32'h12C, 32'h18, 32'h1_00E2};
  wire [21:0] dev_view = {bypass_en, charge_pump_current, feedback_div, predivide_ratio,
    adc_clk_ratio, vco_ratio, div_conflict};
  dpll_if dpll_if_inst ();
  dpll_host #(.PAUSE_CYCLES(8)) dpll_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(dpll_if_inst.host));
  dpll_dev dpll_dev_inst (.pclk(pclk), .presetn(presetn), .link(dpll_if_inst.dev),
    .pll_locked(pll_locked), .bypass_en(bypass_en), .charge_pump_current(charge_pump_current),
    .feedback_div(feedback_div), .predivide_ratio(predivide_ratio),
    .adc_clk_ratio(adc_clk_ratio), .vco_ratio(vco_ratio), .div_conflict(div_conflict),
    .vco_cal_start(vco_cal_start));
  dpll_link_monitor dpll_link_monitor_inst (.pclk(pclk), .presetn(presetn),
    .req(dpll_if_inst.req), .we(dpll_if_inst.we), .addr(dpll_if_inst.addr),
    .wdata(dpll_if_inst.wdata), .ack(dpll_if_inst.ack), .rdata(dpll_if_inst.rdata));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (vco_cal_start === 1'b1) cal_cnt++;
  end
  // ==========================================================
  // tasks
  task automatic conclude();
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 64) begin
      n++;
      @(posedge pclk);
    end
    if (pready !== 1'b1) begin
      failures++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input logic [31:0] cfg, input logic [31:0] rf, input logic [31:0] ctl);
    int n;
    n = 0;
    cal_cnt = 0;
    apb(1'b1, `DPLL_APB_CFG, cfg);
    apb(1'b1, `DPLL_APB_REF, rf);
    apb(1'b1, `DPLL_APB_CTRL, ctl);
    do begin
      apb(1'b0, `DPLL_APB_STAT, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 200);
    if (rd[0] !== 1'b0) begin
      failures++;
      conclude();
    end
  endtask
  initial begin
    repeat (50000) @(posedge pclk);
    failures++;
    conclude();
  end
  // ==========================================================
  // scenarios
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pll_locked = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `DPLL_APB_STAT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    chk({10'h0, dev_view}, {10'h0, 1'b0, 6'h00, 6'h00, 3'h1, 3'h1, 2'h1, 1'b0});
    run(32'h0, 32'h0, 32'h3);
    chk(rd, 32'h2);
    chk({31'h0, bypass_en}, 32'h1);
    chk(cal_cnt, 32'h0);
    apb(1'b0, `DPLL_APB_CTRL, 32'h0);
    chk(rd, 32'h2);
    for (int i = 0; i < 6; i++) begin
      run(bad_cfg[i], bad_ref[i], 32'h1);
      chk(rd & 32'h9, 32'h8);
      chk(cal_cnt, 32'h0);
    end
    pll_locked <= 1'b1;
    run(32'h0029_2008, 32'h0000_012C, 32'h1);
    chk(rd, 32'h6);
    chk({10'h0, dev_view}, {10'h0, 1'b0, 6'h08, 6'h20, 3'h2, 3'h3, 2'h3, 1'b0});
    chk(cal_cnt, 32'h1);
    pll_locked <= 1'b0;
    run(32'h0013_0204, 32'h0001_0064, 32'h1);
    chk(rd, 32'h12);
    chk({10'h0, dev_view}, {10'h0, 1'b0, 6'h04, 6'h02, 3'h4, 3'h1, 2'h2, 1'b0});
    conclude();
  end
endmodule
